// ---- dpr_addr_ctr.sv ----
// Internal address counter with load, advance and clear
`default_nettype none
module dpr_addr_ctr
    import dpr_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic step,
    input wire logic load_n,
    input wire logic advance_n,
    input wire logic clear_n,
    input wire logic [AW-1:0] ext_addr,
    output logic [AW-1:0] access_addr,
    output logic [AW-1:0] count
);
    logic [AW-1:0] next_count;

    // Choose the address used by this cycle's access
    always_comb begin
        if (!clear_n) begin
            access_addr = AW'(ADDR_ZERO);
        end else if (!load_n) begin
            access_addr = ext_addr;
        end else if (!advance_n) begin
            access_addr = count + AW'(1);
        end else begin
            access_addr = count;
        end
        next_count = step ? access_addr : count;
    end

    // Counter register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count <= AW'(ADDR_ZERO);
        end else begin
            count <= next_count;
        end
    end
endmodule : dpr_addr_ctr
`default_nettype wire

// ---- dpr_ctl_model.sv ----
// Bus master model that drives the pins of one RAM port
`default_nettype none
module dpr_ctl_model
    import dpr_pkg::*;
(
    input wire logic sys_clk,
    output var logic chip_select_low_active_n = 1'b1,
    output var logic chip_select_high_active = 1'b0,
    output var logic read_write = 1'b1,
    output var logic output_enable_n = 1'b1,
    output var logic upper_byte_select_n = 1'b1,
    output var logic lower_byte_select_n = 1'b1,
    output var logic address_strobe_load_n = 1'b1,
    output var logic counter_advance_n = 1'b1,
    output var logic counter_clear_n = 1'b1,
    output var logic [ADDR_W-1:0] address = 15'h0000,
    output var logic [DATA_W-1:0] data_in = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pins change just after the edge and stand for the whole cycle; one word feeds all lanes
    task automatic put(input logic [8:0] c, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        {chip_select_low_active_n, chip_select_high_active, read_write, output_enable_n,
            upper_byte_select_n, lower_byte_select_n, address_strobe_load_n,
            counter_advance_n, counter_clear_n} <= c;
        address <= a;
        data_in <= c[6] ? ~data_in : d; // Data lines toggle when not writing
    endtask : put
endmodule : dpr_ctl_model
`default_nettype wire

// ---- dpr_mem.sv ----
// Byte-writable storage array with registered read data
`default_nettype none
module dpr_mem
    import dpr_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input wire logic sys_clk,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic [LANES-1:0] wr_lane,
    input wire logic rd_en,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] cells [0:(2**AW)-1];

    // Write per lane and read old contents into the data register
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_lane[i]) begin
                cells[addr][i*BYTE_W +: BYTE_W] <= wdata[i*BYTE_W +: BYTE_W];
            end
        end
        if (rd_en) begin
            rdata <= cells[addr];
        end
    end
endmodule : dpr_mem
`default_nettype wire

// ---- dpr_pkg.sv ----
// Shared constants for one synchronous dual-port RAM port
//
// Operation
// - Address, data and every control input except the output drive enable are registered on the rising clock edge.
// - Registered write completes on its own, independent of later clock inputs.
// - Output drive enable gates data drivers combinationally, without a clock edge.
// - Port powers down for any registered cycle with a chip select inactive.
// - Pipelined mode re-enables outputs only after two consecutive active cycles.
// - Strobe low uses external address; strobe high uses counter output.
// - Advance low increments address; the access, writes included, uses it.
// - Without load or advance the address holds, so read data stays constant.
// - Counter clear has no idle cycle; a same-cycle access reaches address zero.
// - Strobe held low loads a fresh external address on every edge; the counter here loads only on edges with both chip selects active.
// - Output drive state follows the controls registered one cycle earlier.
// - Outputs go high impedance after the next edge once a chip select drops; in pipelined mode the code turns them off one edge later.
// - A byte whose byte select was high for the read is not driven.
// - Latency select high gives pipelined timing, low gives flow-through; static.
`default_nettype none
package dpr_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int LANES = 2;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [LANES-1:0] DRIVE_OFF = 2'h0;
    localparam int LANE_UPPER = 1;
    localparam int LANE_LOWER = 0;

    // Port activity as seen by the registered chip selects
    typedef enum logic [1:0] {
        DPR_IDLE,
        DPR_WAKE,
        DPR_ACTIVE
    } dpr_act_t;
endpackage : dpr_pkg
`default_nettype wire

// ---- dpr_port.sv ----
// One port of a synchronous dual-port RAM: input registers, counter, array, outputs
`default_nettype none
module dpr_port
    import dpr_pkg::*;
#(
    parameter int AW = ADDR_W,
    parameter int DW = DATA_W
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chip_select_low_active_n,
    input wire logic chip_select_high_active,
    input wire logic read_write,
    input wire logic output_enable_n,
    input wire logic upper_byte_select_n,
    input wire logic lower_byte_select_n,
    input wire logic address_strobe_load_n,
    input wire logic counter_advance_n,
    input wire logic counter_clear_n,
    input wire logic output_latency_select,
    input wire logic [AW-1:0] address,
    input wire logic [DW-1:0] data_in,
    output logic [DW-1:0] data_out,
    output logic [LANES-1:0] data_out_drive,
    output logic power_down,
    output logic [AW-1:0] internal_address
);
    // Registered copies of the port inputs
    logic cs0_r;
    logic cs1_r;
    logic rw_r;
    logic ub_r;
    logic lb_r;
    logic ads_r;
    logic counter_advance_r;
    logic counter_clear_r;
    logic pipe_r;
    logic [AW-1:0] addr_r;
    logic [DW-1:0] din_r;
    logic next_cs0;
    logic next_cs1;
    logic next_rw;
    logic next_ub;
    logic next_lb;
    logic next_ads;
    logic next_counter_advance;
    logic next_counter_clear;
    logic next_pipe;
    logic [AW-1:0] next_addr;
    logic [DW-1:0] next_din;

    // Access and output state
    logic port_active;
    logic [AW-1:0] access_addr;
    logic [AW-1:0] count;
    logic [LANES-1:0] wr_lane;
    logic rd_en;
    logic [DW-1:0] ft_data;
    logic [DW-1:0] pipe_data;
    logic [DW-1:0] next_pipe_data;
    logic [LANES-1:0] ft_drive;
    logic [LANES-1:0] pipe_drive;
    logic [LANES-1:0] next_ft_drive;
    logic [LANES-1:0] next_pipe_drive;
    dpr_act_t act;
    dpr_act_t next_act;
    logic power_down_q;
    logic next_power_down;
    logic [AW-1:0] next_internal;

    // Byte lanes requested low-active, packed upper then lower
    function automatic logic [LANES-1:0] lanes_of(input logic ub_n, input logic lb_n);
        lanes_of = {~ub_n, ~lb_n};
    endfunction : lanes_of

    // Input stage: next values are the pins
    always_comb begin
        next_cs0 = chip_select_low_active_n;
        next_cs1 = chip_select_high_active;
        next_rw = read_write;
        next_ub = upper_byte_select_n;
        next_lb = lower_byte_select_n;
        next_ads = address_strobe_load_n;
        next_counter_advance = counter_advance_n;
        next_counter_clear = counter_clear_n;
        next_pipe = output_latency_select;
        next_addr = address;
        next_din = data_in;
    end

    // Input registers; reset leaves the port deselected with no access pending
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cs0_r <= 1'b1;
            cs1_r <= 1'b0;
            rw_r <= 1'b1;
            ub_r <= 1'b1;
            lb_r <= 1'b1;
            ads_r <= 1'b1;
            counter_advance_r <= 1'b1;
            counter_clear_r <= 1'b1;
            pipe_r <= 1'b0;
            addr_r <= AW'(ADDR_ZERO);
            din_r <= DW'(DATA_RESET);
        end else begin
            cs0_r <= next_cs0;
            cs1_r <= next_cs1;
            rw_r <= next_rw;
            ub_r <= next_ub;
            lb_r <= next_lb;
            ads_r <= next_ads;
            counter_advance_r <= next_counter_advance;
            counter_clear_r <= next_counter_clear;
            pipe_r <= next_pipe;
            addr_r <= next_addr;
            din_r <= next_din;
        end
    end

    // Either chip select inactive in a registered cycle powers the port down
    assign port_active = !cs0_r && cs1_r;

    // Counter resolves load, advance and clear for the registered cycle
    dpr_addr_ctr #(
        .AW(AW)
    ) u_ctr (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .step(port_active),
        .load_n(ads_r),
        .advance_n(counter_advance_r),
        .clear_n(counter_clear_r),
        .ext_addr(addr_r),
        .access_addr(access_addr),
        .count(count)
    );

    // Write lanes and read strobe from the registered controls
    always_comb begin
        wr_lane = DRIVE_OFF;
        rd_en = 1'b0;
        if (port_active) begin
            if (rw_r) begin
                rd_en = 1'b1;
            end else begin
                wr_lane = lanes_of(ub_r, lb_r);
            end
        end
    end

    // Array: the write lands at the next edge with no further input needed
    dpr_mem #(
        .AW(AW),
        .DW(DW)
    ) u_mem (
        .sys_clk(sys_clk),
        .addr(access_addr),
        .wdata(din_r),
        .wr_lane(wr_lane),
        .rd_en(rd_en),
        .rdata(ft_data)
    );

    // Activity tracker: pipelined outputs wake after two active cycles
    always_comb begin
        case (act)
            DPR_IDLE: next_act = port_active ? DPR_WAKE : DPR_IDLE;
            DPR_WAKE: next_act = port_active ? DPR_ACTIVE : DPR_IDLE;
            DPR_ACTIVE: next_act = port_active ? DPR_ACTIVE : DPR_IDLE;
            default: next_act = DPR_IDLE;
        endcase
    end

    // Drive state from the previous cycle's controls, per byte lane
    always_comb begin
        next_ft_drive = DRIVE_OFF;
        if (port_active && rw_r) begin
            next_ft_drive = lanes_of(ub_r, lb_r);
        end
        // Tracker is active only when this read's cycle and the one before were both selected
        next_pipe_drive = DRIVE_OFF;
        if (act == DPR_ACTIVE) begin
            next_pipe_drive = ft_drive;
        end
        next_pipe_data = ft_data;
        next_power_down = !port_active;
        next_internal = access_addr;
    end

    // Output-side registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            act <= DPR_IDLE;
            ft_drive <= DRIVE_OFF;
            pipe_drive <= DRIVE_OFF;
            pipe_data <= DW'(DATA_RESET);
            power_down_q <= 1'b1;
            internal_address <= AW'(ADDR_ZERO);
        end else begin
            act <= next_act;
            ft_drive <= next_ft_drive;
            pipe_drive <= next_pipe_drive;
            pipe_data <= next_pipe_data;
            power_down_q <= next_power_down;
            internal_address <= next_internal;
        end
    end

    // Latency select picks the stage; the output enable gates it without a clock
    always_comb begin
        if (pipe_r) begin
            data_out = pipe_data;
            data_out_drive = pipe_drive & {LANES{!output_enable_n}};
        end else begin
            data_out = ft_data;
            data_out_drive = ft_drive & {LANES{!output_enable_n}};
        end
    end

    assign power_down = power_down_q;
endmodule : dpr_port
`default_nettype wire

// ---- dpr_port_sva.sv ----
// Concurrent checks on the ports of one RAM port
`default_nettype none
module dpr_port_sva
    import dpr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic chip_select_low_active_n,
    input wire logic chip_select_high_active,
    input wire logic read_write,
    input wire logic output_enable_n,
    input wire logic upper_byte_select_n,
    input wire logic address_strobe_load_n,
    input wire logic counter_advance_n,
    input wire logic counter_clear_n,
    input wire logic output_latency_select,
    input wire logic [ADDR_W-1:0] address,
    input wire logic [LANES-1:0] data_out_drive,
    input wire logic power_down,
    input wire logic [ADDR_W-1:0] internal_address
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Both chip selects active
    wire logic cs_on = !chip_select_low_active_n && chip_select_high_active;

    // Address path, output drive and power-down relations
    oe_gate_a: assert property (
        output_enable_n |-> data_out_drive == DRIVE_OFF) else $error("drive with enable high");
    pd_track_a: assert property (
        1'b1 |=> power_down == !$past(cs_on, 2)) else $error("power down wrong");
    addr_load_a: assert property (
        cs_on && counter_clear_n && !address_strobe_load_n
        |-> ##2 internal_address == $past(address, 2))
        else $error("external address not used");
    addr_clear_a: assert property (
        cs_on && !counter_clear_n |-> ##2 internal_address == ADDR_ZERO)
        else $error("clear missed");
    addr_adv_a: assert property (
        cs_on ##1 (cs_on && counter_clear_n && address_strobe_load_n && !counter_advance_n)
        |-> ##2 internal_address == $past(internal_address) + 15'h0001)
        else $error("advance wrong");
    addr_hold_a: assert property (
        cs_on ##1 (cs_on && counter_clear_n && address_strobe_load_n && counter_advance_n)
        |-> ##2 $stable(internal_address)) else $error("address moved on hold");
    flow_off_a: assert property (
        !output_latency_select && !cs_on |-> ##2 data_out_drive == DRIVE_OFF)
        else $error("drive after deselect");
    pipe_wake_a: assert property (
        output_latency_select && !cs_on ##1 cs_on |-> ##3 data_out_drive == DRIVE_OFF)
        else $error("early re-activation");
    byte_off_a: assert property (
        !output_latency_select && cs_on && read_write && upper_byte_select_n
        |-> ##2 !data_out_drive[LANE_UPPER]) else $error("deselected lane driven");
endmodule : dpr_port_sva
`default_nettype wire

// ---- dpr_port_tb.sv ----
// Self-checking bench for one RAM port against a behavioural model
`default_nettype none
module dpr_port_tb import dpr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int due; int d; logic [1:0] drv; int ia; bit rd;} dpr_exp_t;
    localparam logic [8:0] C_RD = 9'h0c3;
    localparam logic [8:0] C_WR = 9'h083;
    localparam logic [8:0] C_IDLE = 9'h17f;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic output_latency_select = 1'b0;
    wire logic chip_select_low_active_n, chip_select_high_active, read_write, output_enable_n;
    wire logic upper_byte_select_n, lower_byte_select_n, address_strobe_load_n;
    wire logic counter_advance_n, counter_clear_n, power_down;
    wire logic [ADDR_W-1:0] address, internal_address;
    wire logic [DATA_W-1:0] data_in, data_out;
    wire logic [LANES-1:0] data_out_drive;
    int mismatches = 0, check_count = 0, cyc = 0, ctr = 0, lat = 0;
    bit prv;
    int mem [32768];
    int ad [8];
    dpr_exp_t q [$];

    always #50 sys_clk = ~sys_clk;

    dpr_ctl_model ctl_u (.sys_clk(sys_clk), .chip_select_low_active_n(chip_select_low_active_n),
        .chip_select_high_active(chip_select_high_active), .read_write(read_write),
        .output_enable_n(output_enable_n), .upper_byte_select_n(upper_byte_select_n),
        .lower_byte_select_n(lower_byte_select_n), .address_strobe_load_n(address_strobe_load_n),
        .counter_advance_n(counter_advance_n), .counter_clear_n(counter_clear_n),
        .address(address), .data_in(data_in));
    dpr_port dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .chip_select_low_active_n(chip_select_low_active_n),
        .chip_select_high_active(chip_select_high_active), .read_write(read_write),
        .output_enable_n(output_enable_n), .upper_byte_select_n(upper_byte_select_n),
        .lower_byte_select_n(lower_byte_select_n), .address_strobe_load_n(address_strobe_load_n),
        .counter_advance_n(counter_advance_n), .counter_clear_n(counter_clear_n),
        .output_latency_select(output_latency_select), .address(address), .data_in(data_in),
        .data_out(data_out), .data_out_drive(data_out_drive), .power_down(power_down),
        .internal_address(internal_address));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report

    // One cycle: drive pins, update the model, then compare what falls due
    task automatic op(input logic [8:0] c, input int a, input int d);
        dpr_exp_t e;
        int x;
        int m;
        bit on;
        logic [15:0] mk;
        ctl_u.put(c, a[14:0], d[15:0]);
        cyc++;
        on = !c[8] && c[7];
        m = (c[4] ? 0 : 32'hff00) | (c[3] ? 0 : 32'h00ff);
        x = !c[0] ? 0 : !c[2] ? a : !c[1] ? (ctr + 1) & 32'h7fff : ctr;
        // Address and power state after every active cycle and the first idle one
        if (on || prv) q.push_back('{cyc + 2, !on, 2'h0, x, 1'b0});
        if (on) begin
            ctr = x;
            if (!c[6]) mem[x] = (mem[x] & ~m) | (d & m);
            else q.push_back('{cyc + 2 + lat, mem[x], (prv || lat == 0) ? ~c[4:3] : 2'h0, 0, 1'b1});
        end
        prv = on;
        @(negedge sys_clk);
        while (q.size() > 0 && q[0].due == cyc) begin
            e = q.pop_front();
            mk = {{8{e.drv[1]}}, {8{e.drv[0]}}};
            if (!e.rd) begin
                chk({1'b0, internal_address}, e.ia[15:0]);
                chk({15'h0, power_down}, {15'h0, e.d[0]});
            end else begin
                chk({14'h0, data_out_drive}, {14'h0, e.drv & {2{!output_enable_n}}});
                if (e.drv != 2'h0) chk(data_out & mk, e.d[15:0] & mk);
            end
        end
    endtask : op

    // Reset, then the whole sequence at one latency setting
    task automatic suite(input int l);
        int w;
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        output_latency_select <= l[0];
        lat = l;
        ctr = 0;
        repeat (10) op(C_IDLE, 0, 0);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        foreach (ad[i]) op(C_WR, ad[i], $urandom);
        for (int i = 0; i < 8; i += 2) op(C_WR | 9'h008, ad[i], $urandom);
        foreach (ad[i]) op(C_RD | (9'($urandom) & 9'h018), ad[i], 0);
        op(C_RD, 32'h7fff, 0);
        op(C_RD ^ 9'h006, 0, 0);
        repeat (2) op(C_RD | 9'h006, 0, 0);
        op(C_RD & 9'h1fe, ad[2], 0);
        op(C_RD | 9'h020, ad[3], 0);
        op(C_RD & 9'h17f, ad[4], 0);
        repeat (2) op(C_RD, ad[4], 0);
        op(C_WR ^ 9'h006, 0, $urandom);
        op(C_RD, (ad[4] + 1) & 32'h7fff, 0);
        w = $urandom;
        op(C_IDLE, 0, 0);
        repeat (2) op(C_WR, ad[5], w);
        op(C_RD, ad[5], 0);
        op({!w[16], w[16], C_RD[6:0]}, ad[6], 0);
        repeat (4) op(C_IDLE, 0, 0);
        $display("suite with latency select %0d done", l);
    endtask : suite

    // Main sequence: flow-through first, then pipelined
    initial begin
        void'($urandom(32'h0f15811d));
        foreach (ad[i]) ad[i] = $urandom & 32'h7fff;
        ad[0] = 0;
        ad[1] = 32'h7fff;
        for (int s = 0; s < 2; s++) begin
            suite(s);
        end
        final_report();
    end

    // Cut a hung run short well past the expected length
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule : dpr_port_tb
bind dpr_port dpr_port_sva chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .chip_select_low_active_n(chip_select_low_active_n),
    .chip_select_high_active(chip_select_high_active), .read_write(read_write),
    .output_enable_n(output_enable_n), .upper_byte_select_n(upper_byte_select_n),
    .address_strobe_load_n(address_strobe_load_n), .counter_advance_n(counter_advance_n),
    .counter_clear_n(counter_clear_n), .output_latency_select(output_latency_select),
    .address(address), .data_out_drive(data_out_drive), .power_down(power_down),
    .internal_address(internal_address));
`default_nettype wire
